// ### rtl/ext_instr_regs.svh
// constants for the extended pointer instruction decode and execute block
// assumes a 21-bit program counter and a 12-bit data address space
`ifndef EXT_INSTR_REGS_SVH
`define EXT_INSTR_REGS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define XI_PC_W 21
`define XI_ADDR_W 12

// ----------------------------------------------------------------------
// opcode fields of the first word
// ----------------------------------------------------------------------
`define XI_OPC_MSB 15
`define XI_OPC_LSB 8
`define XI_OPC_PTR_ADD 8'he8
`define XI_OPC_PTR_SUB 8'he9
`define XI_OPC_PUSH 8'hea
`define XI_OPC_MOVE 8'heb
`define XI_OPC_CALL 16'h0014
`define XI_SEL_MSB 7
`define XI_SEL_LSB 6
`define XI_SEL_FRAME 2'h3
`define XI_K6_MSB 5
`define XI_K8_MSB 7
`define XI_MV_KIND_BIT 7
`define XI_Z_MSB 6

// ----------------------------------------------------------------------
// second word of the two-word moves
// ----------------------------------------------------------------------
`define XI_W2_TAG_MSB 15
`define XI_W2_TAG_LSB 12
`define XI_W2_TAG 4'hf
`define XI_ABS_MSB 11

// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define XI_RET_OFS 21'h000002
`define XI_PTR_RST 12'h000
`define XI_PUSH_DEC 12'h001
`define XI_FRAME_IDX 2'h2
`define XI_ZERO_BYTE 8'h00
`define XI_IND_BASE0 12'hfeb
`define XI_IND_BASE1 12'hfe3
`define XI_IND_BASE2 12'hfdb
`define XI_IND_SPAN 12'h005

`endif

// ### rtl/xi_pkg.sv
// types shared by the extended pointer instruction block
// assumes ext_instr_regs.svh on the include path
`include "ext_instr_regs.svh"

package xi_pkg;

  typedef enum logic [1:0] {
    st_ready = 2'b00,
    st_idle_cycle = 2'b01,
    st_move_read = 2'b10,
    st_move_dest = 2'b11
  } state_t;

  typedef enum logic [3:0] {
    op_none = 4'b0000,
    op_ptr_add = 4'b0001,
    op_frame_add_ret = 4'b0010,
    op_ptr_sub = 4'b0011,
    op_frame_sub_ret = 4'b0100,
    op_reg_call = 4'b0101,
    op_lit_push = 4'b0110,
    op_move_abs = 4'b0111,
    op_move_idx = 4'b1000
  } op_t;

  typedef struct packed {
    logic load;
    logic [`XI_PC_W-1:0] value;
  } redirect_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [`XI_PC_W-1:0] value;
  } stack_op_t;

  typedef struct packed {
    logic we;
    logic [`XI_ADDR_W-1:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic re;
    logic [`XI_ADDR_W-1:0] addr;
  } mem_rd_t;

  typedef logic [2:0][`XI_ADDR_W-1:0] ptr_bank_t;

endpackage

// ### rtl/ext_opcode_decode.sv
// combinational decode of one instruction word into an extended operation
// assumes the caller gates it with the synchronised extension enable
`timescale 1ns/100ps
`include "ext_instr_regs.svh"

module ext_opcode_decode (
  input wire logic [15:0] word,
  input wire logic enable,
  output xi_pkg::op_t op
);

  always_comb begin
    op = xi_pkg::op_none;
    if (!enable) begin
      op = xi_pkg::op_none;
    end else if (word == `XI_OPC_CALL) begin
      op = xi_pkg::op_reg_call;
    end else if (word[`XI_OPC_MSB:`XI_OPC_LSB] == `XI_OPC_PTR_ADD) begin
      if (word[`XI_SEL_MSB:`XI_SEL_LSB] == `XI_SEL_FRAME) begin
        op = xi_pkg::op_frame_add_ret;
      end else begin
        op = xi_pkg::op_ptr_add;
      end
    end else if (word[`XI_OPC_MSB:`XI_OPC_LSB] == `XI_OPC_PTR_SUB) begin
      if (word[`XI_SEL_MSB:`XI_SEL_LSB] == `XI_SEL_FRAME) begin
        op = xi_pkg::op_frame_sub_ret;
      end else begin
        op = xi_pkg::op_ptr_sub;
      end
    end else if (word[`XI_OPC_MSB:`XI_OPC_LSB] == `XI_OPC_PUSH) begin
      op = xi_pkg::op_lit_push;
    end else if (word[`XI_OPC_MSB:`XI_OPC_LSB] == `XI_OPC_MOVE) begin
      if (word[`XI_MV_KIND_BIT]) begin
        op = xi_pkg::op_move_idx;
      end else begin
        op = xi_pkg::op_move_abs;
      end
    end
  end

endmodule // ext_opcode_decode

// ### rtl/indirect_reg_check.sv
// flags a data address that falls on one of the indirect access registers
// assumes three groups of consecutive indirect registers
`timescale 1ns/100ps
`include "ext_instr_regs.svh"

module indirect_reg_check (
  input wire logic [`XI_ADDR_W-1:0] addr,
  output logic hit
);

  function automatic logic in_group(input logic [`XI_ADDR_W-1:0] a,
                                    input logic [`XI_ADDR_W-1:0] base);
    in_group = (a >= base) && (a < base + `XI_IND_SPAN);
  endfunction

  always_comb begin
    hit = in_group(addr, `XI_IND_BASE0) || in_group(addr, `XI_IND_BASE1) ||
          in_group(addr, `XI_IND_BASE2);
  end

endmodule // indirect_reg_check

// ### rtl/extended_pointer_instr_exec.sv
// decode and execute of the eight extended pointer instructions
// assumes fetch offers words with valid/ready on this clock and a data
// memory that answers a read combinationally in the same cycle
//
// Summary of operation
// (RULE1) pointer add; select three means frame add-return
// (RULE2) frame add-return adds literal to frame pointer
// (RULE3) then loads program counter from stack top
// (RULE4) frame add-return takes two cycles
// (RULE5) call pushes instruction address plus two
// (RULE6) call puts accumulator in counter low byte
// (RULE7) call copies latches into high, upper bytes
// (RULE8) call takes two cycles, second idle
// (RULE9) call saves no accumulator, status or bank
// (RULE10) call decoded from single fixed opcode
// (RULE11) pointer subtract literal, one cycle, no flags
// (RULE12) frame subtract-return, two cycles
// (RULE13) literal push stores then decrements frame pointer
// (RULE14) indexed-to-absolute move, two words, two cycles; code takes three clocks, with a read cycle between the words
// (RULE15) indexed-to-indexed move, two words, two cycles; code takes three clocks, with a read cycle between the words
// (RULE16) extension active only when enable set
// (RULE17) indirect source address reads as zero
// (RULE18) indirect indexed destination makes move idle
// (RULE19) returns pop the return stack
`timescale 1ns/100ps
`include "ext_instr_regs.svh"

module extended_pointer_instr_exec (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic extension_enable_cfg,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [`XI_PC_W-1:0] instr_addr,
  input wire logic [7:0] working_accumulator,
  input wire logic [7:0] counter_latch_high,
  input wire logic [4:0] counter_latch_upper,
  input wire logic [`XI_PC_W-1:0] return_stack_top,
  input wire logic [7:0] mem_rdata,
  output logic instr_ready,
  output logic std_pass,
  output logic [15:0] std_word,
  output xi_pkg::redirect_t redirect,
  output xi_pkg::stack_op_t stack_op,
  output xi_pkg::mem_rd_t mem_rd,
  output xi_pkg::mem_wr_t mem_wr,
  output xi_pkg::ptr_bank_t pointers
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  xi_pkg::state_t state_reg;
  xi_pkg::state_t state_next;
  xi_pkg::op_t cur_op;
  logic en_meta_reg;
  logic en_sync_reg;
  logic accept;
  logic [1:0] sel;
  logic [5:0] k6;
  logic [`XI_ADDR_W-1:0] k6_ext;
  logic [`XI_ADDR_W-1:0] src_addr;
  logic [`XI_ADDR_W-1:0] dst_addr;
  logic src_ind;
  logic dst_ind;
  logic src_ind_reg;
  logic move_idx_reg;
  logic [7:0] src_data_reg;
  logic tag_ok;
  logic dest_blocked;

  function automatic logic [`XI_ADDR_W-1:0] idx_addr(input logic [`XI_ADDR_W-1:0] base,
                                                     input logic [6:0] ofs);
    idx_addr = base + {{(`XI_ADDR_W-7){1'b0}}, ofs};
  endfunction

  // ----------------------------------------------------------------------
  // enable synchroniser and decode
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      en_meta_reg <= extension_enable_cfg;
      en_sync_reg <= en_meta_reg;
    end
  end

  // (RULE16) gated by enable
  // (RULE10) fixed call opcode
  ext_opcode_decode u_decode (
    .word(instr_word),
    .enable(en_sync_reg),
    .op(cur_op)
  );

  assign accept = instr_valid && instr_ready;
  assign sel = instr_word[`XI_SEL_MSB:`XI_SEL_LSB];
  assign k6 = instr_word[`XI_K6_MSB:0];
  assign k6_ext = {{(`XI_ADDR_W-6){1'b0}}, k6};
  assign src_addr = idx_addr(pointers[`XI_FRAME_IDX], instr_word[`XI_Z_MSB:0]);
  assign dst_addr = move_idx_reg ? idx_addr(pointers[`XI_FRAME_IDX], instr_word[`XI_Z_MSB:0])
                                 : instr_word[`XI_ABS_MSB:0];
  assign tag_ok = instr_word[`XI_W2_TAG_MSB:`XI_W2_TAG_LSB] == `XI_W2_TAG;
  // (RULE18) indexed destination on indirect register
  assign dest_blocked = move_idx_reg && dst_ind;

  indirect_reg_check u_src_check (
    .addr(src_addr),
    .hit(src_ind)
  );

  indirect_reg_check u_dst_check (
    .addr(dst_addr),
    .hit(dst_ind)
  );

  // ----------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      xi_pkg::st_ready: begin
        if (accept) begin
          case (cur_op)
            xi_pkg::op_frame_add_ret, xi_pkg::op_frame_sub_ret,
            xi_pkg::op_reg_call: state_next = xi_pkg::st_idle_cycle;
            xi_pkg::op_move_abs, xi_pkg::op_move_idx: state_next = xi_pkg::st_move_read;
            default: state_next = xi_pkg::st_ready;
          endcase
        end
      end
      xi_pkg::st_idle_cycle: state_next = xi_pkg::st_ready;
      xi_pkg::st_move_read: state_next = xi_pkg::st_move_dest;
      xi_pkg::st_move_dest: begin
        if (accept) begin
          state_next = xi_pkg::st_ready;
        end
      end
      default: state_next = xi_pkg::st_ready;
    endcase
  end

  // (RULE4) second cycle idle while fetch redirects
  // (RULE8) call idle cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= xi_pkg::st_ready;
      instr_ready <= 1'b0;
    end else begin
      state_reg <= state_next;
      instr_ready <= (state_next == xi_pkg::st_ready) || (state_next == xi_pkg::st_move_dest);
    end
  end

  // ----------------------------------------------------------------------
  // pointer bank
  // ----------------------------------------------------------------------
  // (RULE1) add to selected pointer
  // (RULE2) frame add before return
  // (RULE11) subtract, flags untouched
  // (RULE12) frame subtract before return
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pointers <= {3{`XI_PTR_RST}};
    end else if (accept && state_reg == xi_pkg::st_ready) begin
      case (cur_op)
        xi_pkg::op_ptr_add: pointers[sel] <= pointers[sel] + k6_ext;
        xi_pkg::op_ptr_sub: pointers[sel] <= pointers[sel] - k6_ext;
        xi_pkg::op_frame_add_ret:
          pointers[`XI_FRAME_IDX] <= pointers[`XI_FRAME_IDX] + k6_ext;
        xi_pkg::op_frame_sub_ret:
          pointers[`XI_FRAME_IDX] <= pointers[`XI_FRAME_IDX] - k6_ext;
        xi_pkg::op_lit_push:
          pointers[`XI_FRAME_IDX] <= pointers[`XI_FRAME_IDX] - `XI_PUSH_DEC;
        default: pointers <= pointers;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // program flow and return stack
  // ----------------------------------------------------------------------
  // (RULE3) return loads stack top
  // (RULE19) return pops stack
  // (RULE5) push instruction address plus two
  // (RULE6) accumulator into low byte
  // (RULE7) latches into high and upper
  // (RULE9) no shadow save on call
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      redirect <= '0;
      stack_op <= '0;
    end else begin
      redirect.load <= 1'b0;
      stack_op.push <= 1'b0;
      stack_op.pop <= 1'b0;
      if (accept && state_reg == xi_pkg::st_ready) begin
        if (cur_op == xi_pkg::op_frame_add_ret || cur_op == xi_pkg::op_frame_sub_ret) begin
          redirect.load <= 1'b1;
          redirect.value <= return_stack_top;
          stack_op.pop <= 1'b1;
        end else if (cur_op == xi_pkg::op_reg_call) begin
          stack_op.push <= 1'b1;
          stack_op.value <= instr_addr + `XI_RET_OFS;
          redirect.load <= 1'b1;
          redirect.value <= {counter_latch_upper, counter_latch_high, working_accumulator};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // data memory and moves
  // ----------------------------------------------------------------------
  // (RULE14) absolute move source read
  // (RULE15) indexed move source read
  // (RULE17) indirect source reads zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mem_rd <= '0;
      src_ind_reg <= 1'b0;
      move_idx_reg <= 1'b0;
      src_data_reg <= `XI_ZERO_BYTE;
    end else begin
      mem_rd.re <= 1'b0;
      if (accept && state_reg == xi_pkg::st_ready &&
          (cur_op == xi_pkg::op_move_abs || cur_op == xi_pkg::op_move_idx)) begin
        mem_rd.re <= !src_ind;
        mem_rd.addr <= src_addr;
        src_ind_reg <= src_ind;
        move_idx_reg <= cur_op == xi_pkg::op_move_idx;
      end
      if (state_reg == xi_pkg::st_move_read) begin
        src_data_reg <= src_ind_reg ? `XI_ZERO_BYTE : mem_rdata;
      end
    end
  end

  // (RULE13) literal stored at frame pointer
  // (RULE18) blocked destination writes nothing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mem_wr <= '0;
    end else begin
      mem_wr.we <= 1'b0;
      if (accept && state_reg == xi_pkg::st_ready && cur_op == xi_pkg::op_lit_push) begin
        mem_wr.we <= 1'b1;
        mem_wr.addr <= pointers[`XI_FRAME_IDX];
        mem_wr.data <= instr_word[`XI_K8_MSB:0];
      end else if (accept && state_reg == xi_pkg::st_move_dest && tag_ok &&
                   !dest_blocked) begin
        mem_wr.we <= 1'b1;
        mem_wr.addr <= dst_addr;
        mem_wr.data <= src_data_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // hand-off of standard words
  // ----------------------------------------------------------------------
  // (RULE16) disabled extension passes words on
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      std_pass <= 1'b0;
      std_word <= 16'h0000;
    end else begin
      std_pass <= accept && ((state_reg == xi_pkg::st_ready && cur_op == xi_pkg::op_none) ||
                             (state_reg == xi_pkg::st_move_dest && !tag_ok));
      if (accept) begin
        std_word <= instr_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic go;
  assign go = accept && state_reg == xi_pkg::st_ready;

  ptr_add_a: assert property (go && cur_op == xi_pkg::op_ptr_add |=> // RULE1
    pointers[$past(sel)] == $past(pointers[sel]) + $past(k6_ext))
    else $error("pointer add result wrong");

  frame_add_a: assert property (go && cur_op == xi_pkg::op_frame_add_ret |=> // RULE2
    pointers[`XI_FRAME_IDX] == $past(pointers[`XI_FRAME_IDX]) + $past(k6_ext))
    else $error("frame add result wrong");

  return_pop_a: assert property (go && (cur_op == xi_pkg::op_frame_add_ret || // RULE3
    cur_op == xi_pkg::op_frame_sub_ret) |=> redirect.load && stack_op.pop &&
    !stack_op.push && redirect.value == $past(return_stack_top))
    else $error("return did not load and pop");

  two_cycle_a: assert property (go && (cur_op == xi_pkg::op_reg_call || // RULE4
    cur_op == xi_pkg::op_frame_sub_ret || cur_op == xi_pkg::op_frame_add_ret)
    |=> !instr_ready ##1 instr_ready)
    else $error("two cycle instruction timing wrong");

  call_push_a: assert property (go && cur_op == xi_pkg::op_reg_call |=> // RULE5
    stack_op.push && stack_op.value == $past(instr_addr) + `XI_RET_OFS)
    else $error("call return address wrong");

  call_target_a: assert property (go && cur_op == xi_pkg::op_reg_call |=> // RULE6
    redirect.load && redirect.value == {$past(counter_latch_upper),
    $past(counter_latch_high), $past(working_accumulator)})
    else $error("call target wrong");

  ptr_sub_a: assert property (go && cur_op == xi_pkg::op_ptr_sub |=> // RULE11
    pointers[$past(sel)] == $past(pointers[sel]) - $past(k6_ext) && instr_ready)
    else $error("pointer subtract result wrong");

  lit_push_a: assert property (go && cur_op == xi_pkg::op_lit_push |=> // RULE13
    mem_wr.we && mem_wr.addr == $past(pointers[`XI_FRAME_IDX]) &&
    pointers[`XI_FRAME_IDX] == mem_wr.addr - `XI_PUSH_DEC)
    else $error("literal push wrong");

  src_zero_a: assert property (state_reg == xi_pkg::st_move_read && src_ind_reg |=> // RULE17
    src_data_reg == `XI_ZERO_BYTE)
    else $error("indirect source not zero");

  dest_nop_a: assert property (accept && state_reg == xi_pkg::st_move_dest && // RULE18
    dest_blocked |=> !mem_wr.we)
    else $error("blocked destination written");

  ext_off_a: assert property (accept && !en_sync_reg |=> std_pass && // RULE16
    !mem_wr.we && !redirect.load)
    else $error("disabled extension acted");

  call_cov: cover property (go && cur_op == xi_pkg::op_reg_call ##2 instr_ready);
  ret_cov: cover property (go && cur_op == xi_pkg::op_frame_sub_ret ##1 stack_op.pop);
  move_cov: cover property (state_reg == xi_pkg::st_move_dest && accept ##1 mem_wr.we);
  push_cov: cover property (go && cur_op == xi_pkg::op_lit_push);

endmodule // extended_pointer_instr_exec

// ### verification/extended_pointer_instr_exec_tb.sv
// self-checking bench for the extended pointer instruction block
// assumes the rtl include path holds ext_instr_regs.svh and xi_pkg is compiled first
`timescale 1ns/100ps
`include "ext_instr_regs.svh"

module extended_pointer_instr_exec_tb;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic extension_enable_cfg = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [`XI_PC_W-1:0] instr_addr = 21'h000000;
  logic [7:0] working_accumulator = 8'h00;
  logic [7:0] counter_latch_high = 8'h00;
  logic [4:0] counter_latch_upper = 5'h00;
  logic [`XI_PC_W-1:0] return_stack_top = 21'h000000;
  wire logic [7:0] mem_rdata;
  logic instr_ready;
  logic std_pass;
  logic [15:0] std_word;
  xi_pkg::redirect_t redirect;
  xi_pkg::stack_op_t stack_op;
  xi_pkg::mem_rd_t mem_rd;
  xi_pkg::mem_wr_t mem_wr;
  xi_pkg::ptr_bank_t pointers;
  logic [11:0] exp_ptr [3];
  int n_errors = 0;
  int total_checks = 0;

  always #4 clock = ~clock;

  // memory answers every address with a pattern derived from it
  assign mem_rdata = mem_rd.addr[7:0] ^ 8'h5a;

  extended_pointer_instr_exec dut (
    .clock(clock), .arst_n(arst_n), .extension_enable_cfg(extension_enable_cfg),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr),
    .working_accumulator(working_accumulator), .counter_latch_high(counter_latch_high),
    .counter_latch_upper(counter_latch_upper), .return_stack_top(return_stack_top),
    .mem_rdata(mem_rdata), .instr_ready(instr_ready), .std_pass(std_pass),
    .std_word(std_word), .redirect(redirect), .stack_op(stack_op), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .pointers(pointers)
  );

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_ptrs();
    for (int i = 0; i < 3; i++) begin
      check("pointer", 32'(pointers[i]), 32'(exp_ptr[i]));
    end
  endtask

  // offers one word and returns at the falling edge after it is taken
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clock);
    instr_valid = 1'b1;
    instr_word = w;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    if (n == 20) begin
      n_errors++;
      $display("BAD accept expected 1 seen 0");
    end
    @(negedge clock);
    instr_valid = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic do_reset();
    @(negedge clock);
    arst_n = 1'b0;
    repeat (4) @(negedge clock);
    check("ready in reset", 32'(instr_ready), 32'h0);
    check("push in reset", 32'(stack_op.push), 32'h0);
    check("write in reset", 32'(mem_wr.we), 32'h0);
    for (int i = 0; i < 3; i++) exp_ptr[i] = 12'h000;
    check_ptrs();
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
  endtask

  task automatic t_ptr_arith();
    logic [5:0] k;
    for (int f = 0; f < 3; f++) begin
      k = 6'h3f - 6'(f);
      issue({8'he8, 2'(f), k});
      exp_ptr[f] = exp_ptr[f] + 12'(k);
      check_ptrs();
      check("add no return", 32'(redirect.load), 32'h0);
    end
    for (int f = 0; f < 3; f++) begin
      k = 6'h01 + 6'(f);
      issue({8'he9, 2'(f), k});
      exp_ptr[f] = exp_ptr[f] - 12'(k);
      check_ptrs();
      check("sub one cycle", 32'(instr_ready), 32'h1);
    end
  endtask

  task automatic t_frame_ret(input logic sub, input logic [5:0] k);
    return_stack_top = sub ? 21'h1a5c3 : 21'h0f00e;
    issue({sub ? 8'he9 : 8'he8, 2'b11, k});
    exp_ptr[2] = sub ? exp_ptr[2] - 12'(k) : exp_ptr[2] + 12'(k);
    check_ptrs();
    check("return load", 32'(redirect.load), 32'h1);
    check("return target", 32'(redirect.value), 32'(return_stack_top));
    check("return pop", 32'(stack_op.pop), 32'h1);
    check("return busy", 32'(instr_ready), 32'h0);
    @(negedge clock);
    check("return idle done", 32'(instr_ready), 32'h1);
    check("return load once", 32'(redirect.load), 32'h0);
  endtask

  task automatic t_call();
    instr_addr = 21'h1000fe;
    working_accumulator = 8'h06;
    counter_latch_high = 8'h10;
    counter_latch_upper = 5'h1f;
    issue(16'h0014);
    check("call push", 32'(stack_op.push), 32'h1);
    check("call return addr", 32'(stack_op.value), 32'h100100);
    check("call no pop", 32'(stack_op.pop), 32'h0);
    check("call load", 32'(redirect.load), 32'h1);
    check("call target", 32'(redirect.value), 32'h1f1006);
    check("call busy", 32'(instr_ready), 32'h0);
    check_ptrs();
    @(negedge clock);
    check("call idle done", 32'(instr_ready), 32'h1);
    issue(16'h0015);
    check("near call pass", 32'(std_pass), 32'h1);
    check("near call no push", 32'(stack_op.push), 32'h0);
  endtask

  task automatic t_push();
    logic [11:0] old;
    old = exp_ptr[2];
    issue(16'hea77);
    check("push write", 32'(mem_wr.we), 32'h1);
    check("push addr", 32'(mem_wr.addr), 32'(old));
    check("push data", 32'(mem_wr.data), 32'h77);
    exp_ptr[2] = old - 12'h001;
    check_ptrs();
  endtask

  task automatic t_move(input logic [15:0] w1, input logic [15:0] w2, input logic re,
                        input logic [11:0] ra, input logic we, input logic [11:0] wa,
                        input logic [7:0] wd);
    issue(w1);
    check("move read", 32'(mem_rd.re), 32'(re));
    if (re) check("move read addr", 32'(mem_rd.addr), 32'(ra));
    check("move busy", 32'(instr_ready), 32'h0);
    issue(w2);
    check("move write", 32'(mem_wr.we), 32'(we));
    if (we) begin
      check("move write addr", 32'(mem_wr.addr), 32'(wa));
      check("move data", 32'(mem_wr.data), 32'(wd));
    end
    check("move no pass", 32'(std_pass), 32'h0);
  endtask

  task automatic t_moves();
    logic [11:0] a;
    a = exp_ptr[2] + 12'h005;
    t_move(16'heb05, 16'hf123, 1'b1, a, 1'b1, 12'h123, a[7:0] ^ 8'h5a);
    a = exp_ptr[2] + 12'h001;
    t_move(16'heb81, 16'hf002, 1'b1, a, 1'b1, exp_ptr[2] + 12'h002, a[7:0] ^ 8'h5a);
    // second word without the f tag drops the move and is handed on
    issue(16'heb05);
    issue(16'h1234);
    check("bad tag no write", 32'(mem_wr.we), 32'h0);
    check("bad tag pass", 32'(std_pass), 32'h1);
    check("bad tag word", 32'(std_word), 32'h1234);
  endtask

  task automatic t_indirect();
    do_reset();
    issue({8'he9, 2'b10, 6'h30});
    exp_ptr[2] = 12'hfd0;
    check_ptrs();
    t_move(16'heb0b, 16'hf456, 1'b0, 12'h000, 1'b1, 12'h456, 8'h00);
    t_move(16'heb81, 16'hf013, 1'b1, 12'hfd1, 1'b0, 12'h000, 8'h00);
  endtask

  task automatic t_disabled();
    extension_enable_cfg = 1'b0;
    repeat (3) @(negedge clock);
    issue(16'he801);
    check("off pass", 32'(std_pass), 32'h1);
    check("off word", 32'(std_word), 32'he801);
    check_ptrs();
    issue(16'h0014);
    check("off call pass", 32'(std_pass), 32'h1);
    check("off call push", 32'(stack_op.push), 32'h0);
    extension_enable_cfg = 1'b1;
    repeat (3) @(negedge clock);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    t_ptr_arith();
    t_frame_ret(1'b0, 6'h23);
    t_frame_ret(1'b1, 6'h3f);
    t_call();
    t_push();
    t_moves();
    t_disabled();
    t_indirect();
    tally_and_finish();
  end

  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end
endmodule // extended_pointer_instr_exec_tb
